//--- pscp_cfg.svh
// pscp_cfg.svh - address map, field positions, reset values and counts for the serial
// control port; included by the package, port and register files of the block, definitions only.
`ifndef PSCP_CFG_SVH
`define PSCP_CFG_SVH

// full address is page bits above the seven transmitted address bits;
// three page bits, since the top window at 0x200 sits above two-bit pages
`define PSCP_ADDR_W        10
`define PSCP_LOCAL_W       7
`define PSCP_PAGE_W        3

// address windows that the port answers
`define PSCP_RANGE_A_LO    10'h050
`define PSCP_RANGE_A_HI    10'h067
`define PSCP_RANGE_B_LO    10'h0D0
`define PSCP_RANGE_B_HI    10'h0DF
`define PSCP_RANGE_C_LO    10'h140
`define PSCP_RANGE_C_HI    10'h14F
`define PSCP_RANGE_D_LO    10'h200
`define PSCP_RANGE_D_HI    10'h27F

// shared write-only addresses
`define PSCP_SHARED_P0     10'h000
`define PSCP_SHARED_P1     10'h080
`define PSCP_SHARED_LO     10'h100
`define PSCP_SHARED_HI     10'h106

// registers that steer the block
`define PSCP_ADDR_RAIL_A   10'h05D
`define PSCP_ADDR_RAIL_B   10'h05E
`define PSCP_ADDR_IF_CFG   10'h105
`define PSCP_ADDR_IF_CFG2  10'h106
`define PSCP_LOCAL_PAGE    7'h00

// field positions
`define PSCP_RAIL_EN       0
`define PSCP_RAIL_PD_DIS   1
`define PSCP_RAIL_GPI_SEL  2
`define PSCP_IFC_SEL_POL   0
`define PSCP_IFC_DIR_POL   1
`define PSCP_IFC_IDLE      2
`define PSCP_IFC_PHASE     3
`define PSCP_PAGE_PAGE_AUTO_RETURN   7

// reset values
`define PSCP_RAIL_RST      8'h00
`define PSCP_IF_CFG_RST    8'h00
`define PSCP_IF_CFG2_RST   8'h00
`define PSCP_PAGE_RST      3'h0
`define PSCP_IF4_RST       1'b1
`define PSCP_STANDALONE_RST 1'b0

// frame bit counts
`define PSCP_CNT_W         5
`define PSCP_CNT_ADDR_LAST 5'h06
`define PSCP_CNT_CMD_LAST  5'h07
`define PSCP_CNT_LAST      5'h0F

`endif

//--- pscp_host.sv
// pscp_host.sv - behavioural host that clocks four-wire frames.
// assumes the bench calls xfer between sys_clk edges and sets cfg while idle.
module pscp_host (
  input  wire logic sys_clk,
  input  wire logic so,
  input  wire logic so_oe,
  output logic      cs,
  output logic      sck,
  output logic      si
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cfg = 4'h0; // phase, idle, direction, select polarity
  logic       oe_seen;
  initial begin
    cs = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  ////////////////////////////////////////////////
  task automatic hw(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one frame of nb bits; data pin toggles once released so stale bits never pass
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd,
                      input int nb, output logic [7:0] rdat);
    logic [15:0] w;
    w = {a, rd ^ cfg[1], wd};
    oe_seen = 1'b0;
    cs <= ~cfg[0];
    sck <= cfg[2];
    hw(6);
    cs <= cfg[0];
    for (int i = 15; i >= 16 - nb; i--) begin
      if (!cfg[3]) si <= (rd && i < 8) ? ~si : w[i];
      hw(10);
      oe_seen = oe_seen | so_oe;
      if (!cfg[3] && i < 8) rdat[i] = so_oe ? so : ~so;
      sck <= ~sck;
      if (cfg[3]) si <= (rd && i < 8) ? ~si : w[i];
      hw(10);
      oe_seen = oe_seen | so_oe;
      if (cfg[3] && i < 8) rdat[i] = so_oe ? so : ~so;
      sck <= ~sck;
    end
    hw(10);
    cs <= ~cfg[0];
    si <= ~si;
    hw(4);
  endtask
endmodule

//--- pscp_pkg.sv
// pscp_pkg.sv - types shared by the serial control port modules.
// assumes pscp_cfg.svh is on the include path.
`include "pscp_cfg.svh"

package pscp_pkg;

  // full register address, page bits on top
  typedef logic [`PSCP_ADDR_W-1:0] pscp_addr_t;

  // frame progress of the four-wire port
  typedef enum logic [2:0] {
    PSCP_IDLE  = 3'h0,
    PSCP_CMD   = 3'h1,
    PSCP_WRITE = 3'h2,
    PSCP_READ  = 3'h3,
    PSCP_SKIP  = 3'h4,
    PSCP_DONE  = 3'h5
  } pscp_frame_t;

endpackage

//--- pscp_port.sv
// pscp_port.sv - serial control port of the buck regulator PMU: mode gating, rail enables,
// four-wire 16-bit frame engine, address filtering and register paging.
// assumes serial_clock, chip_select, serial_in and the enable pins come from outside
// sys_clk and are oversampled; the serial clock stays well below a quarter of sys_clk.
//
// What this block does
// RULE1 - host waits the start-up delay after chip enable before any frame.
// RULE2 - in on mode a set rail enable powers that rail up.
// RULE3 - general input levels are taken at on entry so active levels act at once.
// RULE4 - rail off without enables; pull-down follows its pull-down disable bit.
// RULE5 - off mode: rails and pull-downs off, every pin high impedance.
// RULE6 - fuse read picks two- or four-wire; four-wire claims the shared pins.
// RULE7 - only addresses inside the four answered windows get a response.
// RULE8 - out-of-range accesses are ignored and serial output stays undriven.
// RULE9 - top window is writable only in debug or production mode; the code unlocks it on debug_mode alone.
// RULE10 - shared write-only addresses accept writes, reads leave output undriven.
// RULE11 - host reads shared registers first and changes only non-reserved fields.
// RULE12 - standalone fuse bit lets the shared write-only addresses answer reads.
// RULE13 - interface configuration comes from writes to the two shared config registers.
// RULE14 - eight pages of 128 with page register at zero; page zero after reset.
// RULE15 - page register write always switches page; with auto-return set, page zero returns after the next frame.
// RULE16 - each transfer is one 16-bit half-duplex frame clocked by the host.
// RULE17 - seven address bits then direction bit; address decoded after seventh bit.
// RULE18 - write frames carry eight data bits in; reads shift eight out, MSB first.
// RULE19 - select polarity is programmable; inactive select resets the frame engine.
// RULE20 - serial output driven only during the data half of a read.
// RULE21 - idle level and phase pick the update and sampling clock edges.
// RULE22 - idle-high phase one updates on falling and samples on rising edges.
// RULE23 - a frame cut short by select release performs no write.
`include "pscp_cfg.svh"

module pscp_port
  import pscp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // mode and fuse inputs
  input  wire logic       chip_enable_pin,
  input  wire logic       fuse_load,
  input  wire logic       fuse_if_4wire,
  input  wire logic       fuse_standalone,
  input  wire logic       debug_mode,
  // general inputs for rail control
  input  wire logic [1:0] general_input,
  // four-wire link pins
  input  wire logic       chip_select,
  input  wire logic       serial_clock,
  input  wire logic       serial_in,
  output logic            serial_out_q,
  output logic            serial_out_oe_q,
  // pin mux and rail controls
  output logic            shared_pins_if_q,
  output logic            rail_a_on_q,
  output logic            rail_b_on_q,
  output logic            rail_a_pulldown_q,
  output logic            rail_b_pulldown_q
);

  ////////////////////////////////////////////////////////////////////////////
  // address classification

  function automatic logic in_win(input pscp_addr_t a, input pscp_addr_t lo,
                                  input pscp_addr_t hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  // answered windows, used by both the read and the write checks
  function automatic logic answered(input pscp_addr_t a);
    answered = in_win(a, `PSCP_RANGE_A_LO, `PSCP_RANGE_A_HI) ||
               in_win(a, `PSCP_RANGE_B_LO, `PSCP_RANGE_B_HI) ||
               in_win(a, `PSCP_RANGE_C_LO, `PSCP_RANGE_C_HI) ||
               in_win(a, `PSCP_RANGE_D_LO, `PSCP_RANGE_D_HI);
  endfunction

  // shared write-only addresses
  function automatic logic shared_wo(input pscp_addr_t a);
    shared_wo = (a == `PSCP_SHARED_P0) || (a == `PSCP_SHARED_P1) ||
                in_win(a, `PSCP_SHARED_LO, `PSCP_SHARED_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [5:0]  sync_lvl;
  logic        s_cs;
  logic        s_sclk;
  logic        s_si;
  logic        s_en;
  logic [1:0]  s_gpi;
  logic        on_q;
  logic        on_entry;
  logic        if4_q;
  logic        standalone_q;
  logic [1:0]  gpi_q;
  logic        sclk_prev_q;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        samp_edge;
  logic        upd_edge;
  logic        link_en;
  logic        cs_act;
  pscp_frame_t state_q;
  logic [`PSCP_CNT_W-1:0] cnt_q;
  logic [7:0]  shift_q;
  logic [7:0]  so_shift_q;
  pscp_addr_t  addr_q;
  pscp_addr_t  addr_now;
  logic        rd_ok_q;
  logic        wr_ok_q;
  logic        is_read;
  logic [`PSCP_PAGE_W-1:0] page_q;
  logic        page_auto_return_q;
  logic        wr_en_q;
  pscp_addr_t  wr_addr_q;
  logic [7:0]  wr_data_q;
  logic [7:0]  wdata_now;
  logic        frame_end;
  logic        page_hit;
  logic [7:0]  reg_rdata;
  logic [7:0]  rd_value;
  logic [7:0]  rail_a_ctrl;
  logic [7:0]  rail_b_ctrl;
  logic [7:0]  if_cfg;
  logic        rail_a_d;
  logic        rail_b_d;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and helpers

  pscp_sync #(.W(6)) u_sync (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .pin_lvl  ({general_input, chip_enable_pin, serial_in, serial_clock, chip_select}),
    .sync_lvl (sync_lvl)
  );

  assign s_cs   = sync_lvl[0];
  assign s_sclk = sync_lvl[1];
  assign s_si   = sync_lvl[2];
  assign s_en   = sync_lvl[3];
  assign s_gpi  = sync_lvl[5:4];

  // on mode follows the synchronised enable pin
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_q <= 1'b0;
    end else begin
      on_q <= s_en;
    end
  end

  assign on_entry = s_en & ~on_q;

  // interface type and standalone bit are caught at the fuse read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      if4_q        <= `PSCP_IF4_RST;
      standalone_q <= `PSCP_STANDALONE_RST;
    end else if (fuse_load) begin
      if4_q        <= fuse_if_4wire;    // [RULE6]
      standalone_q <= fuse_standalone;  // [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rail control

  // general inputs are dropped while off, taken live from on entry onward
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gpi_q <= 2'h0;
    end else if (on_entry || on_q) begin
      gpi_q <= s_gpi;  // [RULE3]
    end else begin
      gpi_q <= 2'h0;
    end
  end

  assign rail_a_d = on_q & (rail_a_ctrl[`PSCP_RAIL_EN] |
                            (rail_a_ctrl[`PSCP_RAIL_GPI_SEL] & gpi_q[0])); // [RULE2]
  assign rail_b_d = on_q & (rail_b_ctrl[`PSCP_RAIL_EN] |
                            (rail_b_ctrl[`PSCP_RAIL_GPI_SEL] & gpi_q[1])); // [RULE2]

  // off mode forces rails and pull-downs off regardless of settings
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rail_a_on_q       <= 1'b0;
      rail_b_on_q       <= 1'b0;
      rail_a_pulldown_q <= 1'b0;
      rail_b_pulldown_q <= 1'b0;
      shared_pins_if_q  <= 1'b0;
    end else begin
      rail_a_on_q       <= rail_a_d;
      rail_b_on_q       <= rail_b_d;
      rail_a_pulldown_q <= on_q & ~rail_a_d & ~rail_a_ctrl[`PSCP_RAIL_PD_DIS]; // [RULE4] [RULE5]
      rail_b_pulldown_q <= on_q & ~rail_b_d & ~rail_b_ctrl[`PSCP_RAIL_PD_DIS]; // [RULE4] [RULE5]
      shared_pins_if_q  <= on_q & if4_q;  // [RULE6] [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial clock edges and select

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= s_sclk;
    end
  end

  assign sclk_rise = s_sclk & ~sclk_prev_q;
  assign sclk_fall = ~s_sclk & sclk_prev_q;

  // equal idle level and phase sample on rising, otherwise on falling
  assign samp_edge = (if_cfg[`PSCP_IFC_IDLE] == if_cfg[`PSCP_IFC_PHASE]) ?
                     sclk_rise : sclk_fall;  // [RULE21] [RULE22]
  assign upd_edge  = (if_cfg[`PSCP_IFC_IDLE] == if_cfg[`PSCP_IFC_PHASE]) ?
                     sclk_fall : sclk_rise;  // [RULE21] [RULE22]

  // link only works in on mode with four-wire selected
  assign link_en = on_q & if4_q;  // [RULE5] [RULE6]
  assign cs_act  = link_en & (if_cfg[`PSCP_IFC_SEL_POL] ? s_cs : ~s_cs); // [RULE19]

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  assign addr_now  = {page_q, shift_q[5:0], s_si};  // [RULE17]
  assign is_read   = s_si ^ if_cfg[`PSCP_IFC_DIR_POL];  // [RULE17]
  assign wdata_now = {shift_q[6:0], s_si};           // [RULE18]
  assign frame_end = cs_act & samp_edge & (cnt_q == `PSCP_CNT_LAST);
  assign page_hit  = (addr_q[`PSCP_LOCAL_W-1:0] == `PSCP_LOCAL_PAGE);

  // page register reads show the page state, everything else the storage
  assign rd_value = page_hit ? {page_auto_return_q, 4'h0, page_q} : reg_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // frame engine; select release drops a frame anywhere, so no partial write

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PSCP_IDLE;
      cnt_q   <= '0;
      shift_q <= 8'h00;
      addr_q  <= '0;
      rd_ok_q <= 1'b0;
      wr_ok_q <= 1'b0;
    end else if (!cs_act) begin
      state_q <= PSCP_IDLE;  // [RULE19] [RULE23]
      cnt_q   <= '0;
      rd_ok_q <= 1'b0;
      wr_ok_q <= 1'b0;
    end else if (samp_edge) begin
      shift_q <= wdata_now;  // [RULE18]
      cnt_q   <= cnt_q + `PSCP_CNT_W'(1);
      case (state_q)
        PSCP_IDLE, PSCP_CMD: begin
          state_q <= PSCP_CMD;
          if (cnt_q == `PSCP_CNT_ADDR_LAST) begin
            addr_q  <= addr_now;  // [RULE17]
            rd_ok_q <= answered(addr_now) ||
                       (standalone_q && shared_wo(addr_now)); // [RULE7] [RULE10] [RULE12]
            wr_ok_q <= (answered(addr_now) &&
                        (!in_win(addr_now, `PSCP_RANGE_D_LO, `PSCP_RANGE_D_HI) ||
                         debug_mode)) ||
                       shared_wo(addr_now) ||
                       (addr_now[`PSCP_LOCAL_W-1:0] == `PSCP_LOCAL_PAGE); // [RULE9] [RULE10] [RULE14]
          end else if (cnt_q == `PSCP_CNT_CMD_LAST) begin
            if (is_read) begin
              state_q <= rd_ok_q ? PSCP_READ : PSCP_SKIP;  // [RULE8]
            end else begin
              state_q <= wr_ok_q ? PSCP_WRITE : PSCP_SKIP; // [RULE8]
            end
          end
        end
        PSCP_WRITE, PSCP_READ, PSCP_SKIP: begin
          if (cnt_q == `PSCP_CNT_LAST) begin
            state_q <= PSCP_DONE;  // [RULE16]
          end
        end
        PSCP_DONE: begin
          state_q <= PSCP_DONE;  // extra edges wait for select release
        end
        default: begin
          state_q <= PSCP_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output; driven only between first data update and frame end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      so_shift_q      <= 8'h00;
      serial_out_q    <= 1'b0;
      serial_out_oe_q <= 1'b0;
    end else if (!cs_act || (state_q != PSCP_READ)) begin
      serial_out_oe_q <= 1'b0;  // [RULE20] [RULE8] [RULE5]
      so_shift_q      <= rd_value;
    end else if (upd_edge) begin
      serial_out_q    <= so_shift_q[7];  // [RULE18]
      so_shift_q      <= {so_shift_q[6:0], 1'b0};
      serial_out_oe_q <= 1'b1;  // [RULE20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write commit on the sixteenth sampled bit only

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_en_q   <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q   <= frame_end && (state_q == PSCP_WRITE) && !page_hit; // [RULE23]
      wr_addr_q <= addr_q;
      wr_data_q <= wdata_now;
    end
  end

  // paging; auto-return drops back to page zero after the next frame
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      page_q   <= `PSCP_PAGE_RST;  // [RULE14]
      page_auto_return_q <= 1'b0;
    end else if (frame_end) begin
      if ((state_q == PSCP_WRITE) && page_hit) begin
        page_q   <= wdata_now[`PSCP_PAGE_W-1:0];  // [RULE15]
        page_auto_return_q <= wdata_now[`PSCP_PAGE_PAGE_AUTO_RETURN];  // [RULE15]
      end else if (page_auto_return_q) begin
        page_q   <= `PSCP_PAGE_RST;  // [RULE15]
        page_auto_return_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  pscp_regs u_regs (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .wr_en       (wr_en_q),
    .wr_addr     (wr_addr_q),
    .wr_data     (wr_data_q),
    .rd_addr     (addr_q),
    .rd_data     (reg_rdata),
    .rail_a_ctrl (rail_a_ctrl),
    .rail_b_ctrl (rail_b_ctrl),
    .if_cfg      (if_cfg)
  );

endmodule

//--- pscp_port_assertions.sv
// pscp_port_assertions.sv - timing checks on the serial control port pins.
// assumes the port's pins only; bound from the testbench top file.
module pscp_port_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // mode and link
  input wire logic chip_enable_pin,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_out_q,
  input wire logic serial_out_oe_q,
  // pin mux and rails
  input wire logic shared_pins_if_q,
  input wire logic rail_a_on_q,
  input wire logic rail_b_on_q,
  input wire logic rail_a_pulldown_q,
  input wire logic rail_b_pulldown_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////
  // off mode, seen after sync and register delay
  property p_off_rails;
    !chip_enable_pin [*6] |-> !rail_a_on_q && !rail_b_on_q && !rail_a_pulldown_q
      && !rail_b_pulldown_q;
  endproperty
  a_off_rails: assert property (p_off_rails)
    else $error("rail or pull-down active in off mode");
  property p_off_hiz;
    !chip_enable_pin [*6] |-> !serial_out_oe_q && !shared_pins_if_q;
  endproperty
  a_off_hiz: assert property (p_off_hiz)
    else $error("pin driven in off mode");
  // pull-down never fights a running rail
  property p_pd_a;
    rail_a_pulldown_q |-> !rail_a_on_q;
  endproperty
  a_pd_a: assert property (p_pd_a)
    else $error("rail a pull-down while on");
  property p_pd_b;
    rail_b_pulldown_q |-> !rail_b_on_q;
  endproperty
  a_pd_b: assert property (p_pd_b)
    else $error("rail b pull-down while on");
  // output moves only a few cycles after a link clock edge, or on release after a select change
  property p_oe_rise;
    $rose(serial_out_oe_q) |-> $past(serial_clock, 3) != $past(serial_clock, 7);
  endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("output enable rose away from a clock edge");
  property p_out_chg;
    serial_out_oe_q && $past(serial_out_oe_q) && $changed(serial_out_q)
      |-> $past(serial_clock, 3) != $past(serial_clock, 7);
  endproperty
  a_out_chg: assert property (p_out_chg)
    else $error("read data moved without a clock edge");
  property p_oe_fall;
    $fell(serial_out_oe_q) && chip_enable_pin |-> $past(serial_clock, 3) !=
      $past(serial_clock, 7) || $past(chip_select, 3) != $past(chip_select, 7);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("output released without edge or select change");
  property p_shared;
    $rose(shared_pins_if_q) |-> $past(chip_enable_pin, 2);
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared pins claimed outside on mode");
  property p_rail_a;
    $rose(rail_a_on_q) |-> $past(chip_enable_pin, 2);
  endproperty
  a_rail_a: assert property (p_rail_a)
    else $error("rail a started outside on mode");
  c_read: cover property ($rose(serial_out_oe_q));
  c_rail_b: cover property ($rose(rail_b_on_q));
  c_pins: cover property ($fell(shared_pins_if_q));
endmodule

//--- pscp_regs.sv
// pscp_regs.sv - register storage behind the serial control port.
// assumes the port gates writes by address range and mode; this file stores only.
`include "pscp_cfg.svh"

module pscp_regs
  import pscp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // write side
  input  wire logic       wr_en,
  input  pscp_addr_t      wr_addr,
  input  wire logic [7:0] wr_data,
  // read side
  input  pscp_addr_t      rd_addr,
  output logic      [7:0] rd_data,
  // fields that steer the block
  output logic      [7:0] rail_a_ctrl,
  output logic      [7:0] rail_b_ctrl,
  output logic      [7:0] if_cfg
);

  // plain data registers; no reset, software owns their content
  logic [7:0] mem [0:(1<<`PSCP_ADDR_W)-1];
  logic [7:0] if_cfg2_q;

  ////////////////////////////////////////////////////////////////////////////
  // control registers with defined reset values
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rail_a_ctrl <= `PSCP_RAIL_RST;
      rail_b_ctrl <= `PSCP_RAIL_RST;
      if_cfg      <= `PSCP_IF_CFG_RST;
      if_cfg2_q   <= `PSCP_IF_CFG2_RST;
    end else if (wr_en) begin
      if (wr_addr == `PSCP_ADDR_RAIL_A) rail_a_ctrl <= wr_data;
      if (wr_addr == `PSCP_ADDR_RAIL_B) rail_b_ctrl <= wr_data;
      if (wr_addr == `PSCP_ADDR_IF_CFG) if_cfg <= wr_data;   // [RULE13]
      if (wr_addr == `PSCP_ADDR_IF_CFG2) if_cfg2_q <= wr_data; // [RULE13]
    end
  end

  // bulk storage
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux: steering registers win over the array copy
  always_comb begin
    case (rd_addr)
      `PSCP_ADDR_RAIL_A:  rd_data = rail_a_ctrl;
      `PSCP_ADDR_RAIL_B:  rd_data = rail_b_ctrl;
      `PSCP_ADDR_IF_CFG:  rd_data = if_cfg;
      `PSCP_ADDR_IF_CFG2: rd_data = if_cfg2_q;
      default:            rd_data = mem[rd_addr];
    endcase
  end

endmodule

//--- pscp_sync.sv
// pscp_sync.sv - two-flop synchroniser for a bundle of pin levels.
// assumes each bit is an independent level from outside the sys_clk domain.
module pscp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  // levels
  input  wire logic [W-1:0] pin_lvl,
  output logic      [W-1:0] sync_lvl
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_lvl <= '0;
    end else begin
      meta_q   <= pin_lvl;
      sync_lvl <= meta_q;
    end
  end

endmodule

//--- test_pmu_serial_control_port.sv
// test_pmu_serial_control_port.sv - self-checking bench for the serial control port.
// assumes pscp_host drives the link; inputs change by nba just after sys_clk edges.
module test_pmu_serial_control_port;
  import pscp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, nrst, chip_enable_pin, fuse_load, fuse_if_4wire, fuse_standalone;
  logic       debug_mode, chip_select, serial_clock, serial_in, serial_out_q;
  logic       serial_out_oe_q, shared_pins_if_q, rail_a_on_q, rail_b_on_q;
  logic       rail_a_pulldown_q, rail_b_pulldown_q;
  logic [1:0] general_input;
  logic [7:0] cfg_tab [4] = '{8'h07, 8'h0A, 8'h0D, 8'h00};
  int         errors = 0;
  int         num_checks = 0;
  pscp_port DUT (.sys_clk(sys_clk), .nrst(nrst), .chip_enable_pin(chip_enable_pin),
    .fuse_load(fuse_load), .fuse_if_4wire(fuse_if_4wire), .fuse_standalone(fuse_standalone),
    .debug_mode(debug_mode), .general_input(general_input), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in), .serial_out_q(serial_out_q),
    .serial_out_oe_q(serial_out_oe_q), .shared_pins_if_q(shared_pins_if_q),
    .rail_a_on_q(rail_a_on_q), .rail_b_on_q(rail_b_on_q),
    .rail_a_pulldown_q(rail_a_pulldown_q), .rail_b_pulldown_q(rail_b_pulldown_q));
  pscp_host host (.sys_clk(sys_clk), .so(serial_out_q), .so_oe(serial_out_oe_q),
    .cs(chip_select), .sck(serial_clock), .si(serial_in));
  always #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(a, 1'b0, d, 16, r);
  endtask
  // read that must be answered with the given byte
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer(a, 1'b1, 8'h00, 16, r);
    chk("answered", 8'h01, 8'(host.oe_seen));
    chk("read data", e, r);
  endtask
  // read that must leave the output undriven
  task automatic miss(input logic [6:0] a);
    logic [7:0] r;
    host.xfer(a, 1'b1, 8'h00, 16, r);
    chk("output enable", 8'h00, 8'(host.oe_seen));
  endtask
  task automatic fuse(input logic four, input logic alone);
    fuse_if_4wire <= four;
    fuse_standalone <= alone;
    fuse_load <= 1'b1;
    @(posedge sys_clk);
    fuse_load <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  // hang guard, well beyond some forty frames
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    conclude();
  end
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    chip_enable_pin = 1'b0;
    fuse_load = 1'b0;
    fuse_if_4wire = 1'b1;
    fuse_standalone = 1'b0;
    debug_mode = 1'b0;
    general_input = 2'h0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    chip_enable_pin <= 1'b1;
    fuse(1'b0, 1'b0);
    chk("pins two-wire", 8'h00, 8'(shared_pins_if_q));
    fuse(1'b1, 1'b0);
    chk("pins four-wire", 8'h01, 8'(shared_pins_if_q));
    repeat (20) @(posedge sys_clk);
    chk("rail b pull-down", 8'h01, 8'(rail_b_pulldown_q));
    wr(7'h5D, 8'h01);
    chk("rail a on", 8'h01, 8'(rail_a_on_q));
    rd(7'h5D, 8'h01);
    wr(7'h5E, 8'h02);
    chk("rail b pull-down", 8'h00, 8'(rail_b_pulldown_q));
    wr(7'h5E, 8'h04);
    general_input <= 2'h2;
    repeat (8) @(posedge sys_clk);
    chk("rail b by input", 8'h01, 8'(rail_b_on_q));
    miss(7'h10);
    miss(7'h00);
    host.xfer(7'h5D, 1'b0, 8'h00, 12, cfg_tab[0]);
    rd(7'h5D, 8'h01);
    // page one, then page two with auto return
    wr(7'h00, 8'h01);
    wr(7'h51, 8'hA5);
    rd(7'h51, 8'hA5);
    wr(7'h00, 8'h82);
    wr(7'h4F, 8'h3C);
    rd(7'h5D, 8'h01);
    wr(7'h00, 8'h02);
    rd(7'h4F, 8'h3C);
    wr(7'h00, 8'h04);
    debug_mode <= 1'b1;
    wr(7'h10, 8'h5A);
    debug_mode <= 1'b0;
    wr(7'h10, 8'hC3);
    rd(7'h10, 8'h5A);
    wr(7'h00, 8'h00);
    fuse(1'b1, 1'b1);
    rd(7'h00, 8'h00);
    // every select, direction and clock setting in turn
    cfg_tab = '{8'h07, 8'h0A, 8'h0D, 8'h00};
    for (int k = 0; k < 4; k++) begin
      wr(7'h00, 8'h02);
      rd(7'h05, (k == 0) ? 8'h00 : cfg_tab[k-1]);
      wr(7'h00, 8'h82);
      wr(7'h05, cfg_tab[k]);
      host.cfg = cfg_tab[k][3:0];
      wr(7'h5D, 8'(k * 16 + 1));
      rd(7'h5D, 8'(k * 16 + 1));
    end
    // off mode, then on again with the input already active
    chip_enable_pin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("off outputs", 8'h00, {2'h0, serial_out_oe_q, shared_pins_if_q, rail_a_on_q,
        rail_b_on_q, rail_a_pulldown_q, rail_b_pulldown_q});
    chip_enable_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("rail b at on", 8'h01, 8'(rail_b_on_q));
    general_input <= 2'h0;
    conclude();
  end
endmodule

bind pscp_port pscp_port_chk u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .chip_enable_pin(chip_enable_pin), .chip_select(chip_select),
  .serial_clock(serial_clock), .serial_out_q(serial_out_q),
  .serial_out_oe_q(serial_out_oe_q), .shared_pins_if_q(shared_pins_if_q),
  .rail_a_on_q(rail_a_on_q), .rail_b_on_q(rail_b_on_q),
  .rail_a_pulldown_q(rail_a_pulldown_q), .rail_b_pulldown_q(rail_b_pulldown_q));
